/* File: hw/self_prog_pkg.sv */
// constants for the self-programming lock and fuse access block
package self_prog_pkg;

	// register map, byte addresses
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;

	// control register fields
	localparam int CMD_W       = 5;
	localparam int ENABLE_BIT  = 0;
	localparam int BUSY_BIT    = 6;
	localparam int IRQ_EN_BIT  = 7;

	// command patterns in the low five control bits
	localparam logic [4:0] CMD_NONE      = 5'h00;
	localparam logic [4:0] CMD_PAGE_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE     = 5'h03;
	localparam logic [4:0] CMD_WRITE     = 5'h05;
	localparam logic [4:0] CMD_LOCK_SET  = 5'h09;
	localparam logic [4:0] CMD_RWW_EN    = 5'h11;

	// lock and fuse read selects on the Z pointer
	localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
	localparam logic [15:0] Z_LOCK      = 16'h0001;
	localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;

	// lock byte layout
	localparam int BOOT_LOCK_LSB = 2;
	localparam int BOOT_LOCK_MSB = 5;
	localparam logic [1:0] UNUSED_HI = 2'h3;

	// command windows, in cpu cycles
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	localparam logic [2:0] LOAD_WINDOW  = 3'h3;

	// flash programming time
	localparam int PROG_TIME_NS = 4500000;
	localparam int CLK_NS       = 25;
	localparam int PROG_CYCLES  = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_WINDOW = 3'b010,
		ST_PROG   = 3'b100
	} seq_state_e;

endpackage

/* File: hw/down_timer.sv */
// loadable down counter that stops at zero
`timescale 1ns/10ps
module down_timer #(
	parameter int W = 3
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         clear,
	output logic      [W-1:0] cnt
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// refused at elaboration, a zero-width counter cannot hold any load value
	if (W < 1) begin
		$error("down_timer width must be positive");
	end

	always_comb begin
		cnt_nxt = cnt_r;
		if (clear) begin
			cnt_nxt = '0;
		end else if (load) begin
			cnt_nxt = load_val;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - W'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt = cnt_r;

endmodule

/* File: hw/self_prog_ctrl.sv */
// self-programming sequencer with lock and fuse readback behind apb
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
module self_prog_ctrl #(
	parameter int PROG_CYCLES = self_prog_pkg::PROG_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        store_instr,
	input  wire logic        load_instr,
	input  wire logic [15:0] z_ptr,
	input  wire logic [7:0]  working_reg_zero,
	input  wire logic        eeprom_write_busy_bit,
	input  wire logic [7:0]  fuse_low_byte,
	input  wire logic [7:0]  fuse_high_byte,
	input  wire logic [3:0]  boot_lock_state,
	input  wire logic [1:0]  memory_lock_state,
	output logic             load_take,
	output logic [7:0]       load_data,
	output logic             load_valid,
	output logic             lock_prog_strobe,
	output logic [3:0]       lock_prog_mask,
	output logic             rww_read_block,
	output logic             prog_busy,
	output logic             self_prog_irq
);

	localparam int TW = $clog2(PROG_CYCLES + 1);

	// refused at elaboration, the end test needs a count of at least one
	if (PROG_CYCLES < 1) begin
		$error("PROG_CYCLES must be at least one");
	end

	self_prog_pkg::seq_state_e state_r;
	self_prog_pkg::seq_state_e state_nxt;
	logic [4:0]  cmd_r;
	logic [4:0]  cmd_nxt;
	logic        rww_busy_r;
	logic        rww_busy_nxt;
	logic        irq_en_r;
	logic        irq_en_nxt;
	logic [7:0]  load_data_r;
	logic [7:0]  load_data_nxt;
	logic        load_valid_r;
	logic        load_valid_nxt;
	logic        lock_strobe_r;
	logic        lock_strobe_nxt;
	logic [3:0]  lock_mask_r;
	logic [3:0]  lock_mask_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        win_load;
	logic        win_clear;
	logic [2:0]  win_cnt;
	logic        prog_load;
	logic [TW-1:0] prog_cnt;
	logic        wr_ctrl;
	logic        mapped;
	logic        cmd_valid;
	logic        in_load_window;
	logic [7:0]  lock_byte;

	assign mapped  = (paddr == self_prog_pkg::CTRL_ADDR) || (paddr == self_prog_pkg::STATUS_ADDR);
	assign wr_ctrl = psel && penable && pwrite && (paddr == self_prog_pkg::CTRL_ADDR);

	// only the five documented patterns start anything
	always_comb begin
		unique case (pwdata[4:0])
			self_prog_pkg::CMD_PAGE_LOAD,
			self_prog_pkg::CMD_ERASE,
			self_prog_pkg::CMD_WRITE,
			self_prog_pkg::CMD_LOCK_SET,
			self_prog_pkg::CMD_RWW_EN: cmd_valid = 1'b1;
			default:                   cmd_valid = 1'b0;
		endcase
	end

	// load window: counter holds 4,3,2 over the first three cycles
	assign in_load_window = (state_r == self_prog_pkg::ST_WINDOW) &&
		(cmd_r == self_prog_pkg::CMD_LOCK_SET) &&
		(win_cnt > (self_prog_pkg::STORE_WINDOW - self_prog_pkg::LOAD_WINDOW));

	// substitution only inside the window, never with eeprom busy
	assign load_take = in_load_window && load_instr && !eeprom_write_busy_bit;

	// programmed bits are already stored as zero
	assign lock_byte = {self_prog_pkg::UNUSED_HI, boot_lock_state, memory_lock_state};

	down_timer #(.W(3)) u_win (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.load    (win_load),
		.load_val(self_prog_pkg::STORE_WINDOW),
		.clear   (win_clear),
		.cnt     (win_cnt)
	);

	down_timer #(.W(TW)) u_prog (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.load    (prog_load),
		.load_val(TW'(PROG_CYCLES)),
		.clear   (1'b0),
		.cnt     (prog_cnt)
	);

	always_comb begin
		state_nxt       = state_r;
		cmd_nxt         = cmd_r;
		rww_busy_nxt    = rww_busy_r;
		irq_en_nxt      = irq_en_r;
		load_data_nxt   = load_data_r;
		load_valid_nxt  = 1'b0;
		lock_strobe_nxt = 1'b0;
		lock_mask_nxt   = lock_mask_r;
		win_load        = 1'b0;
		win_clear       = 1'b0;
		prog_load       = 1'b0;
		if (wr_ctrl) begin
			irq_en_nxt = pwdata[self_prog_pkg::IRQ_EN_BIT];
		end
		unique case (state_r)
			self_prog_pkg::ST_IDLE: begin
				// a command needs the eeprom idle; otherwise only the interrupt enable bit of the write is taken
				if (wr_ctrl && cmd_valid && !eeprom_write_busy_bit) begin
					cmd_nxt   = pwdata[4:0];
					state_nxt = self_prog_pkg::ST_WINDOW;
					win_load  = 1'b1;
				end
			end
			self_prog_pkg::ST_WINDOW: begin
				if (store_instr && !eeprom_write_busy_bit) begin
					win_clear = 1'b1;
					unique case (cmd_r)
						self_prog_pkg::CMD_ERASE,
						self_prog_pkg::CMD_WRITE: begin
							rww_busy_nxt = 1'b1;
							prog_load    = 1'b1;
							state_nxt    = self_prog_pkg::ST_PROG;
						end
						self_prog_pkg::CMD_LOCK_SET: begin
							// z pointer and bits 7,6,1,0 never reach the lock store
							lock_strobe_nxt = 1'b1;
							lock_mask_nxt   = ~working_reg_zero[self_prog_pkg::BOOT_LOCK_MSB:
								self_prog_pkg::BOOT_LOCK_LSB];
							prog_load       = 1'b1;
							state_nxt       = self_prog_pkg::ST_PROG;
						end
						self_prog_pkg::CMD_RWW_EN: begin
							rww_busy_nxt = 1'b0;
							cmd_nxt      = self_prog_pkg::CMD_NONE;
							state_nxt    = self_prog_pkg::ST_IDLE;
						end
						default: begin
							cmd_nxt   = self_prog_pkg::CMD_NONE;
							state_nxt = self_prog_pkg::ST_IDLE;
						end
					endcase
				end else if (load_take) begin
					win_clear      = 1'b1;
					load_valid_nxt = 1'b1;
					cmd_nxt        = self_prog_pkg::CMD_NONE;
					state_nxt      = self_prog_pkg::ST_IDLE;
					if (z_ptr == self_prog_pkg::Z_FUSE_LOW) begin
						load_data_nxt = fuse_low_byte;
					end else if (z_ptr == self_prog_pkg::Z_LOCK) begin
						load_data_nxt = lock_byte;
					end else if (z_ptr == self_prog_pkg::Z_FUSE_HIGH) begin
						load_data_nxt = fuse_high_byte;
					end else begin
						load_data_nxt = 8'hFF;
					end
				end else if (win_cnt <= 3'h1) begin
					// window ran out with nothing issued
					cmd_nxt   = self_prog_pkg::CMD_NONE;
					state_nxt = self_prog_pkg::ST_IDLE;
				end
			end
			self_prog_pkg::ST_PROG: begin
				if (prog_cnt == TW'(1)) begin
					cmd_nxt   = self_prog_pkg::CMD_NONE;
					state_nxt = self_prog_pkg::ST_IDLE;
				end
			end
			default: begin
				cmd_nxt   = self_prog_pkg::CMD_NONE;
				state_nxt = self_prog_pkg::ST_IDLE;
			end
		endcase
	end

	// read data captured in setup so it is steady through access
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !penable) begin
			prdata_nxt = 32'h0000_0000;
			if (paddr == self_prog_pkg::CTRL_ADDR) begin
				prdata_nxt[4:0]                      = cmd_r;
				prdata_nxt[self_prog_pkg::BUSY_BIT]   = rww_busy_r;
				prdata_nxt[self_prog_pkg::IRQ_EN_BIT] = irq_en_r;
			end else if (paddr == self_prog_pkg::STATUS_ADDR) begin
				prdata_nxt[0] = (state_r == self_prog_pkg::ST_PROG);
				prdata_nxt[1] = (state_r == self_prog_pkg::ST_WINDOW);
				prdata_nxt[2] = eeprom_write_busy_bit;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r       <= self_prog_pkg::ST_IDLE;
			cmd_r         <= self_prog_pkg::CMD_NONE;
			rww_busy_r    <= 1'b0;
			irq_en_r      <= 1'b0;
			load_data_r   <= 8'h00;
			load_valid_r  <= 1'b0;
			lock_strobe_r <= 1'b0;
			lock_mask_r   <= 4'h0;
			prdata_r      <= 32'h0000_0000;
		end else begin
			state_r       <= state_nxt;
			cmd_r         <= cmd_nxt;
			rww_busy_r    <= rww_busy_nxt;
			irq_en_r      <= irq_en_nxt;
			load_data_r   <= load_data_nxt;
			load_valid_r  <= load_valid_nxt;
			lock_strobe_r <= lock_strobe_nxt;
			lock_mask_r   <= lock_mask_nxt;
			prdata_r      <= prdata_nxt;
		end
	end

	assign prdata           = prdata_r;
	assign pready           = 1'b1;
	assign pslverr          = psel && penable && !mapped;
	assign load_data        = load_data_r;
	assign load_valid       = load_valid_r;
	assign lock_prog_strobe = lock_strobe_r;
	assign lock_prog_mask   = lock_mask_r;
	// lock programming leaves reads open; only the page operations set this
	assign rww_read_block   = rww_busy_r;
	assign prog_busy        = (state_r == self_prog_pkg::ST_PROG);
	// level, not pulse, so software may use it instead of polling
	assign self_prog_irq    = irq_en_r && !cmd_r[self_prog_pkg::ENABLE_BIT];

	a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
		self_prog_irq == (irq_en_r && state_r == self_prog_pkg::ST_IDLE))
		else $error("interrupt does not follow enable bit");

	a_busy_blocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_r == self_prog_pkg::ST_PROG && cmd_r != self_prog_pkg::CMD_LOCK_SET) |-> rww_read_block)
		else $error("rww area readable during page operation");

	a_busy_sticks: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(rww_busy_r && !(state_r == self_prog_pkg::ST_WINDOW && cmd_r == self_prog_pkg::CMD_RWW_EN))
		|=> rww_busy_r)
		else $error("busy flag dropped without re-enable");

	a_lock_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_r == self_prog_pkg::ST_WINDOW && cmd_r == self_prog_pkg::CMD_LOCK_SET && store_instr &&
		!eeprom_write_busy_bit) |=> (lock_prog_strobe && lock_prog_mask ==
		~$past(working_reg_zero[self_prog_pkg::BOOT_LOCK_MSB:self_prog_pkg::BOOT_LOCK_LSB])))
		else $error("lock mask does not match register zero");

	a_lock_no_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
		($rose(lock_prog_strobe) && !$past(rww_busy_r)) |-> !rww_read_block)
		else $error("lock programming blocked reads");

	a_eeprom_blocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
		eeprom_write_busy_bit |-> (!load_take ##1 !lock_prog_strobe))
		else $error("access passed during eeprom write");

	a_window_expiry: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_r == self_prog_pkg::ST_IDLE && $past(state_r) == self_prog_pkg::ST_IDLE && wr_ctrl &&
		cmd_valid && !eeprom_write_busy_bit && !pwdata[1] && !pwdata[2]) ##1 (!store_instr && !load_instr) [*4]
		|=> cmd_r == self_prog_pkg::CMD_NONE)
		else $error("enable bits not cleared after window");

	a_load_window: assert property (@(posedge clk_sys) disable iff (!rst_b)
		load_take |-> (win_cnt >= 3'h2 && win_cnt <= 3'h4))
		else $error("load taken outside three-cycle window");

	a_lock_byte: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(load_take && z_ptr == self_prog_pkg::Z_LOCK) |=>
		(load_valid && load_data == {2'h3, $past(boot_lock_state), $past(memory_lock_state)}))
		else $error("lock byte layout wrong");

	a_fuse_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(load_take && z_ptr == self_prog_pkg::Z_FUSE_HIGH) |=> load_data == $past(fuse_high_byte))
		else $error("high fuse byte not returned");

	a_bad_pattern: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_r == self_prog_pkg::ST_IDLE && wr_ctrl && !cmd_valid) |=> state_r == self_prog_pkg::ST_IDLE)
		else $error("undefined pattern started a command");

	c_lock_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
		load_take && z_ptr == self_prog_pkg::Z_LOCK);
	c_page_erase: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(rww_read_block));
	c_lock_prog: cover property (@(posedge clk_sys) disable iff (!rst_b)
		lock_prog_strobe);
	c_rww_reenable: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(rww_busy_r));

endmodule

/* File: test/tb.sv */
// self-checking bench for the self-programming lock and fuse access block
`timescale 1ns/10ps
module tb;
	localparam int PC = 20;
	logic        clk_sys, rst_b, psel, penable, pwrite, store_instr, load_instr, eeprom_write_busy_bit;
	logic [7:0]  paddr, working_reg_zero, fuse_low_byte, fuse_high_byte, load_data;
	logic [31:0] pwdata, prdata;
	logic [15:0] z_ptr;
	logic [3:0]  boot_lock_state, lock_prog_mask;
	logic [1:0]  memory_lock_state;
	logic        pready, pslverr, load_take, load_valid, lock_prog_strobe, rww_read_block, prog_busy, self_prog_irq;
	logic [63:0] rd_q[$];
	logic [7:0]  ld_q[$];
	logic [3:0]  lk_q[$];
	logic [7:0]  r0;
	int          error_cnt, total_checks, seed, cyc, i;
	logic [4:0]  bad [4] = '{5'h07, 5'h13, 5'h19, 5'h0B};

	self_prog_ctrl #(.PROG_CYCLES(PC)) DUT (
		.clk_sys              (clk_sys),
		.rst_b                (rst_b),
		.paddr                (paddr),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.pwdata               (pwdata),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.store_instr          (store_instr),
		.load_instr           (load_instr),
		.z_ptr                (z_ptr),
		.working_reg_zero     (working_reg_zero),
		.eeprom_write_busy_bit(eeprom_write_busy_bit),
		.fuse_low_byte        (fuse_low_byte),
		.fuse_high_byte       (fuse_high_byte),
		.boot_lock_state      (boot_lock_state),
		.memory_lock_state    (memory_lock_state),
		.load_take            (load_take),
		.load_data            (load_data),
		.load_valid           (load_valid),
		.lock_prog_strobe     (lock_prog_strobe),
		.lock_prog_mask       (lock_prog_mask),
		.rww_read_block       (rww_read_block),
		.prog_busy            (prog_busy),
		.self_prog_irq        (self_prog_irq)
	);

	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// expected read data noted before the result edge, compared by the watcher
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] m, input logic err);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		#1 check(pslverr, err);
		if (!w) rd_q.push_back({m, d});
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask

	task ld(input logic [15:0] z, input logic take, input logic [7:0] d);
		load_instr <= 1;
		z_ptr <= z;
		#1 check(load_take, take);
		if (take) ld_q.push_back(d);
		@(posedge clk_sys);
		load_instr <= 0;
	endtask

	task st(input logic [7:0] v);
		store_instr <= 1;
		working_reg_zero <= v;
		z_ptr <= 16'($random(seed));
		@(posedge clk_sys);
		store_instr <= 0;
	endtask

	task wait_idle;
		@(posedge clk_sys);
		#1 check(prog_busy, 1);
		while (prog_busy !== 1'b0) @(posedge clk_sys);
	endtask

	// watcher: takes the oldest note whenever a result shows
	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite) begin
			if (rd_q.size() == 0) check(prdata, 32'hDEADBEEF);
			else begin
				check(prdata & rd_q[0][63:32], rd_q[0][31:0]);
				void'(rd_q.pop_front());
			end
		end
		if (load_valid) begin
			if (ld_q.size() == 0) check(load_data, 32'h1FF);
			else check(load_data, ld_q.pop_front());
		end
		if (lock_prog_strobe) begin
			if (lk_q.size() == 0) check(lock_prog_mask, 32'h1F);
			else check(lock_prog_mask, lk_q.pop_front());
		end
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		seed = 8;
		{rst_b, psel, penable, pwrite, store_instr, load_instr, eeprom_write_busy_bit} = '0;
		paddr = 0;
		pwdata = 0;
		z_ptr = 0;
		working_reg_zero = 8'hFF;
		fuse_low_byte = 8'($random(seed));
		fuse_high_byte = 8'($random(seed));
		boot_lock_state = 4'($random(seed));
		memory_lock_state = 2'($random(seed));
		repeat (3) @(posedge clk_sys);
		rst_b <= 1;
		#1 check({self_prog_irq, rww_read_block, pready}, 3'b001);
		apb(self_prog_pkg::CTRL_ADDR, 0, 0, 32'hFFFFFFFF, 0);
		apb(self_prog_pkg::STATUS_ADDR, 0, 0, 32'hFFFFFFFF, 0);
		apb(8'h08, 0, 0, 32'hFFFFFFFF, 1);
		apb(8'h0C, 1, 32'hFF, 0, 1);
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h80, 0, 0);
		#1 check(self_prog_irq, 1);
		// lock byte and both fuse bytes through the three-cycle window
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h89, 0, 0);
		#1 check(self_prog_irq, 0);
		ld(self_prog_pkg::Z_LOCK, 1, {2'b11, boot_lock_state, memory_lock_state});
		apb(self_prog_pkg::CTRL_ADDR, 0, 32'h80, 32'h9F, 0);
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h89, 0, 0);
		@(posedge clk_sys);
		@(posedge clk_sys);
		ld(self_prog_pkg::Z_FUSE_LOW, 1, fuse_low_byte);
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h89, 0, 0);
		ld(self_prog_pkg::Z_FUSE_HIGH, 1, fuse_high_byte);
		// window runs out after three cycles, load is then a plain flash read
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h89, 0, 0);
		repeat (3) @(posedge clk_sys);
		ld(self_prog_pkg::Z_LOCK, 0, 0);
		apb(self_prog_pkg::CTRL_ADDR, 0, 0, 32'h1F, 0);
		// lock programming with register zero EF, then three random values, flash stays readable
		for (i = 0; i < 4; i++) begin
			r0 = (i != 0) ? 8'($random(seed)) : 8'hEF;
			apb(self_prog_pkg::CTRL_ADDR, 1, 32'h89, 0, 0);
			@(posedge clk_sys);
			@(posedge clk_sys);
			lk_q.push_back(~r0[5:2]);
			st(r0);
			#1 check(rww_read_block, 0);
			wait_idle();
			#1 check(rww_read_block, 0);
		end
		// store window of four cycles runs out
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h89, 0, 0);
		repeat (4) @(posedge clk_sys);
		st(8'h00);
		repeat (2) @(posedge clk_sys);
		// erase and write block the area until re-enabled
		for (i = 0; i < 2; i++) begin
			apb(self_prog_pkg::CTRL_ADDR, 1, i ? 32'h85 : 32'h83, 0, 0);
			st(8'hFF);
			@(posedge clk_sys);
			#1 check({rww_read_block, self_prog_irq}, 2'b10);
			apb(self_prog_pkg::CTRL_ADDR, 0, 32'h40, 32'h40, 0);
			wait_idle();
			#1 check({rww_read_block, self_prog_irq}, 2'b11);
		end
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h91, 0, 0);
		st(8'hFF);
		@(posedge clk_sys);
		#1 check(rww_read_block, 0);
		apb(self_prog_pkg::CTRL_ADDR, 0, 32'h80, 32'hDF, 0);
		// page load is a no-op here and must fire no lock strobe
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h01, 0, 0);
		st(8'h00);
		apb(self_prog_pkg::CTRL_ADDR, 0, 0, 32'h1F, 0);
		// undefined patterns are dropped
		for (i = 0; i < 4; i++) begin
			apb(self_prog_pkg::CTRL_ADDR, 1, {27'h0, bad[i]}, 0, 0);
			apb(self_prog_pkg::CTRL_ADDR, 0, 0, 32'h1F, 0);
		end
		// eeprom write in progress blocks commands and readback
		eeprom_write_busy_bit <= 1;
		apb(self_prog_pkg::STATUS_ADDR, 0, 32'h4, 32'h4, 0);
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h09, 0, 0);
		ld(self_prog_pkg::Z_LOCK, 0, 0);
		apb(self_prog_pkg::CTRL_ADDR, 0, 0, 32'h1F, 0);
		eeprom_write_busy_bit <= 0;
		// eeprom write starting inside an open window still blocks load and store
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h09, 0, 0);
		eeprom_write_busy_bit <= 1'b1;
		ld(self_prog_pkg::Z_FUSE_LOW, 0, 0);
		st(8'h00);
		eeprom_write_busy_bit <= 1'b0;
		repeat (3) @(posedge clk_sys);
		// reset in mid window abandons it
		apb(self_prog_pkg::CTRL_ADDR, 1, 32'h09, 0, 0);
		rst_b <= 0;
		@(posedge clk_sys);
		rst_b <= 1;
		ld(self_prog_pkg::Z_LOCK, 0, 0);
		repeat (3) @(posedge clk_sys);
		stop_test();
	end
endmodule
